// ---- dmr_mode_regs.sv ----
// DRAM configuration words written by the register-set command
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Recovery field optional, parameter selects honouring
// - Base bit A7 selects vendor test mode
// - Base bit A8 set starts loop reset
// - Bit A8 clears itself when reset ends
// - Bank code 001 writes extended word
// - Extended words hold until rewritten; self refresh exit clears A7
// - Impedance field picks auto calibration or nominal
// - Termination 00 disables all terminators
// - Termination 01 keeps only command/address
// - 10/11 quarter/half; low-power needs these
// - Init window forces command/address-only termination, low-power off
// - Preamble length from extended bits A6..A4
// - Self refresh exit re-enables the loop
// - Inversion: A8 read, A9 write, A10 mode
// - Second extended word holds driver offsets
// - Bank code 000 writes base word
// - Bank code 010 writes second extended word
module dmr_mode_regs
  import dmr_pkg::*;
#(
  parameter int         INIT_CYCLES_P = INIT_CYCLES,
  parameter int         DLL_CYCLES_P  = DLL_LOCK_CYCLES,
  parameter logic       WR_IMPL       = 1'b1,
  parameter logic [1:0] TERM_DEFAULT  = TERM_CA_ONLY
)(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Command pins from the controller
  input  wire logic        i_ck,
  input  wire logic        i_cke_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [7:0]  i_adr,
  // Stored words
  output logic      [12:0] o_base_mode_word,
  output logic      [12:0] o_extended_config_word,
  output logic      [12:0] o_second_extended_word,
  // Base word functions
  output logic      [2:0]  o_write_recovery,
  output logic             o_test_mode,
  output logic             o_dll_reset,
  // Extended word functions and self refresh status
  output logic             o_auto_calibration,
  output logic             o_data_term_en,
  output logic             o_ca_term_en,
  output logic             o_term_half,
  output logic             o_low_power_termination,
  output logic      [2:0]  o_preamble_len,
  output logic             o_dll_enable,
  output logic             o_bus_inversion_rd,
  output logic             o_bus_inversion_wr,
  output logic             o_bus_inversion_mode,
  output logic      [1:0]  o_vendor_info,
  output logic             o_self_refresh
);
  typedef struct packed {
    logic        ck_q;      // Last sampled link clock
    logic        cke_prev;  // Clock-enable pin at last edge
    logic        pend;      // Second address beat expected
    logic        pend_wr;   // Pending command is a word write
    logic [7:0]  first;     // First address beat
    logic        in_sr;     // Self refresh active
    logic [12:0] base;      // Base word
    logic [12:0] ext;       // Extended word
    logic [12:0] ext2;      // Second extended word
    logic        lpt;       // Third word low-power bit
    logic        data_term; // Data, mask, strobe termination on
    logic        ca_term;   // Command/address termination on
    logic        half;      // Half calibration impedance
    logic        lp_term;   // Low-power termination active
    logic        auto_cal;  // Automatic calibration selected
  } dmr_state_type;

  dmr_state_type s;       // Current state
  dmr_state_type next_s;  // Next state

  logic        sy_ck;     // Synchronised link clock
  logic        sy_cke_n;  // Synchronised clock enable
  logic        sy_cs_n;   // Synchronised chip select
  logic        sy_ras_n;  // Synchronised row strobe
  logic        sy_cas_n;  // Synchronised column strobe
  logic        sy_we_n;   // Synchronised write enable
  logic [7:0]  sy_adr;    // Synchronised address pins
  logic [12:0] op;        // Op-code assembled from both beats
  logic        wr_base;   // Base word write
  logic        wr_ext;    // Extended word write
  logic        wr_ext2;   // Second extended word write
  logic        wr_ext3;   // Third word write
  logic        sr_exit;   // Self refresh exit seen
  logic        dll_start; // Loop reset requested
  logic        dll_done;  // Loop reset finished
  logic        init_busy; // Power-up window running
  logic        ck_rise;   // Rising edge of link clock
  logic [1:0]  term;      // Termination field after forcing

  // All pins pass two flops before use
  dmr_sync #(.W(14)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   ({i_ck, i_cke_n, i_cs_n, i_ras_n, i_cas_n, i_we_n,
                 i_adr}),
    .o_sync    ({sy_ck, sy_cke_n, sy_cs_n, sy_ras_n, sy_cas_n,
                 sy_we_n, sy_adr})
  );

  // Power-up window, running from reset release
  dmr_timer #(.COUNT(INIT_CYCLES_P), .START_BUSY(1'b1)) u_init (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_start   (1'b0),
    .o_busy    (init_busy),
    .o_done    ()
  );

  // Loop reset duration
  dmr_timer #(.COUNT(DLL_CYCLES_P), .START_BUSY(1'b0)) u_dll (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_start   (dll_start),
    .o_busy    (),
    .o_done    (dll_done)
  );

  // Decode commands on link clock edges and update words
  always_comb
  begin
    next_s    = s;
    ck_rise   = sy_ck & ~s.ck_q;
    op        = dmr_assemble_op(s.first, sy_adr);
    wr_base   = 1'b0;
    wr_ext    = 1'b0;
    wr_ext2   = 1'b0;
    wr_ext3   = 1'b0;
    sr_exit   = 1'b0;
    dll_start = 1'b0;
    next_s.ck_q = sy_ck;
    if (ck_rise)
    begin
      next_s.cke_prev = sy_cke_n;
      if (s.pend)
      begin
        // Second beat completes the pending command
        next_s.pend = 1'b0;
        if (s.pend_wr)
        begin
          unique case (s.first[7:FIRST_BANK_LSB])
            BANK_BASE: wr_base = 1'b1;
            BANK_EXT:  wr_ext  = 1'b1;
            BANK_EXT2: wr_ext2 = 1'b1;
            BANK_EXT3: wr_ext3 = 1'b1;
            default:   wr_base = 1'b0; // Reserved codes ignored
          endcase
        end
      end
      else if (!s.cke_prev && !sy_cke_n && !sy_cs_n &&
               !(sy_ras_n && sy_cas_n && sy_we_n))
      begin
        // Two-beat command: keep first beat
        next_s.pend     = 1'b1;
        next_s.pend_wr  = !sy_ras_n && !sy_cas_n && !sy_we_n;
        next_s.first    = sy_adr;
      end
      else if (!s.cke_prev && sy_cke_n && !sy_cs_n && !sy_ras_n &&
               !sy_cas_n && sy_we_n)
        next_s.in_sr = 1'b1;
      else if (s.in_sr && s.cke_prev && !sy_cke_n)
      begin
        next_s.in_sr = 1'b0;
        sr_exit      = 1'b1;
      end
    end
    // Loop reset ends: bit clears itself
    if (dll_done)
      next_s.base[BASE_DLL_RST_BIT] = 1'b0;
    // Each write touches only its own word
    if (wr_base)
    begin
      next_s.base = op;
      if (!WR_IMPL)
        next_s.base[BASE_WR_LSB +: 3] = 3'h0;
      dll_start = op[BASE_DLL_RST_BIT];
    end
    if (wr_ext)
      next_s.ext = op;
    if (wr_ext2)
      next_s.ext2 = op;
    if (wr_ext3)
      next_s.lpt = op[EXT3_LPT_BIT];
    // Self refresh exit turns the loop back on
    if (sr_exit)
      next_s.ext[EXT_DLL_OFF_BIT] = 1'b0;
    // Keep command/address termination on during power-up
    if (init_busy)
    begin
      next_s.ext[EXT_TERM_LSB +: 2] = TERM_DEFAULT;
      next_s.lpt = 1'b0;
    end
    // Termination and calibration controls
    term             = next_s.ext[EXT_TERM_LSB +: 2];
    next_s.data_term = term[1];
    next_s.ca_term   = (term != TERM_ALL_OFF);
    next_s.half      = (term == TERM_HALF);
    next_s.lp_term   = next_s.lpt & term[1];
    next_s.auto_cal  =
      (next_s.ext[EXT_IMP_LSB +: 2] == IMP_AUTO);
  end

  // Register the whole state
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s           <= '0;
      s.base      <= BASE_RESET;
      s.ext       <= EXT_RESET;
      s.ext2      <= EXT2_RESET;
      s.ca_term   <= 1'b1;
      s.auto_cal  <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Outputs straight from state flops
  assign o_base_mode_word        = s.base;
  assign o_extended_config_word  = s.ext;
  assign o_second_extended_word  = s.ext2;
  assign o_write_recovery        = s.base[BASE_WR_LSB +: 3];
  assign o_test_mode             = s.base[BASE_TEST_BIT];
  assign o_dll_reset             = s.base[BASE_DLL_RST_BIT];
  assign o_auto_calibration      = s.auto_cal;
  assign o_data_term_en          = s.data_term;
  assign o_ca_term_en            = s.ca_term;
  assign o_term_half             = s.half;
  assign o_low_power_termination = s.lp_term;
  assign o_preamble_len          =
    s.ext[EXT_PRE_LSB +: 3];
  assign o_dll_enable            = ~s.ext[EXT_DLL_OFF_BIT];
  assign o_bus_inversion_rd      = s.ext[EXT_INV_RD_BIT];
  assign o_bus_inversion_wr      = s.ext[EXT_INV_WR_BIT];
  assign o_bus_inversion_mode    = s.ext[EXT_INV_MD_BIT];
  assign o_vendor_info           = s.ext[EXT_VID_LSB +: 2];
  assign o_self_refresh          = s.in_sr;

  // Checks
  default clocking dmr_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_dll_req;
    wr_base && op[BASE_DLL_RST_BIT];
  endsequence
  sequence s_dll_hold;
    o_dll_reset [*3];
  endsequence

  property p_dll_start;
    s_dll_req |=> s_dll_hold;
  endproperty
  a_dll_start: assert property (p_dll_start)
    else $error("loop reset bit not held after write");

  property p_dll_clear;
    dll_done && !wr_base |=> !o_dll_reset;
  endproperty
  a_dll_clear: assert property (p_dll_clear)
    else $error("loop reset bit did not self clear");

  property p_base_write;
    wr_base |=> o_test_mode == $past(op[BASE_TEST_BIT]);
  endproperty
  a_base_write: assert property (p_base_write)
    else $error("test mode bit does not follow write");

  property p_ext_write;
    wr_ext && !init_busy |=> o_extended_config_word == $past(op);
  endproperty
  a_ext_write: assert property (p_ext_write)
    else $error("extended word not loaded");

  property p_ext2_write;
    wr_ext2 |=> o_second_extended_word == $past(op);
  endproperty
  a_ext2_write: assert property (p_ext2_write)
    else $error("second extended word not loaded");

  property p_hold;
    !wr_ext2 && !wr_base |=> $stable(o_second_extended_word) &&
      $stable(o_base_mode_word[BASE_TEST_BIT]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("word changed without a write");

  property p_term_off;
    o_extended_config_word[EXT_TERM_LSB +: 2] == TERM_ALL_OFF |->
      !o_ca_term_en && !o_data_term_en;
  endproperty
  a_term_off: assert property (p_term_off)
    else $error("terminators on with field 00");

  property p_init_force;
    init_busy |=> o_ca_term_en && !o_low_power_termination;
  endproperty
  a_init_force: assert property (p_init_force)
    else $error("termination not forced during power-up");

  property p_sr_exit;
    sr_exit |=> o_dll_enable && !o_self_refresh;
  endproperty
  a_sr_exit: assert property (p_sr_exit)
    else $error("loop not enabled at self refresh exit");
endmodule // dmr_mode_regs
`default_nettype wire

// ---- dmr_pkg.sv ----
// Shared constants and helpers of the DRAM configuration word block
package dmr_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int INIT_WINDOW_US  = 200;
  localparam int INIT_CYCLES     =
    (INIT_WINDOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_CYCLES = 512;
  // Widths
  localparam int WORD_W = 13;
  localparam int PIN_W  = 8;
  // Bank codes on the first address beat {BA2,BA1,BA0}
  localparam logic [2:0] BANK_BASE = 3'h0;
  localparam logic [2:0] BANK_EXT  = 3'h1;
  localparam logic [2:0] BANK_EXT2 = 3'h2;
  localparam logic [2:0] BANK_EXT3 = 3'h3;
  localparam int FIRST_BANK_LSB    = 5;
  // Base word fields
  localparam int BASE_WR_LSB      = 0;
  localparam int BASE_TEST_BIT    = 7;
  localparam int BASE_DLL_RST_BIT = 8;
  // Extended word fields
  localparam int EXT_IMP_LSB     = 0;
  localparam int EXT_TERM_LSB    = 2;
  localparam int EXT_PRE_LSB     = 4;
  localparam int EXT_DLL_OFF_BIT = 7;
  localparam int EXT_INV_RD_BIT  = 8;
  localparam int EXT_INV_WR_BIT  = 9;
  localparam int EXT_INV_MD_BIT  = 10;
  localparam int EXT_VID_LSB     = 11;
  localparam int EXT3_LPT_BIT    = 5;
  // Encodings
  localparam logic [1:0] TERM_ALL_OFF = 2'h0;
  localparam logic [1:0] TERM_CA_ONLY = 2'h1;
  localparam logic [1:0] TERM_HALF    = 2'h3;
  localparam logic [1:0] IMP_AUTO     = 2'h0;
  // Reset values
  localparam logic [12:0] BASE_RESET = 13'h0000;
  localparam logic [12:0] EXT_RESET  = 13'h0004;
  localparam logic [12:0] EXT2_RESET = 13'h0000;

  // Rebuild A12..A0 from the two address beats
  function automatic logic [12:0] dmr_assemble_op(
    input logic [7:0] first,
    input logic [7:0] second
  );
    dmr_assemble_op = {first[4:0], second[1], second[7], second[6],
                       second[0], second[3], second[4], second[5],
                       second[2]};
  endfunction
endpackage

// ---- dmr_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module dmr_sync
  import dmr_pkg::*;
#(
  parameter int W = 1
)(
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // Asynchronous input and synchronised output
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;   // First stage, read only by second
    logic [W-1:0] sync;   // Second stage
  } dmr_sync_type;

  dmr_sync_type s;       // Current state
  dmr_sync_type next_s;  // Next state

  // Shift the pins through both stages
  always_comb
  begin
    next_s      = s;
    next_s.meta = i_async;
    next_s.sync = s.meta;
  end

  // Register the stages
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_sync = s.sync;
endmodule // dmr_sync
`default_nettype wire

// ---- dmr_timer.sv ----
// Reloadable down-counter giving a busy level and a done pulse
`timescale 1ns/10ps
`default_nettype none
module dmr_timer
  import dmr_pkg::*;
#(
  parameter int   COUNT      = 16,
  parameter logic START_BUSY = 1'b0
)(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Control and status
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);
  localparam int CW = $clog2(COUNT + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;   // Cycles left
    logic          busy;  // Interval running
    logic          done;  // End pulse
  } dmr_timer_type;

  dmr_timer_type s;       // Current state
  dmr_timer_type next_s;  // Next state

  // Count down, reload on start
  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    if (i_start)
    begin
      next_s.cnt  = CW'(COUNT - 1);
      next_s.busy = 1'b1;
    end
    else if (s.busy)
    begin
      if (s.cnt == '0)
      begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
      else
        next_s.cnt = s.cnt - 1'b1;
    end
  end

  // Register the counter, loaded at reset whether or not starting busy
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s.cnt  <= CW'(COUNT - 1);
      s.busy <= START_BUSY;
      s.done <= 1'b0;
    end
    else
      s <= next_s;
  end

  assign o_busy = s.busy;
  assign o_done = s.done;
endmodule // dmr_timer
`default_nettype wire

// ---- dmr_ctrl_model.sv ----
// Behavioural memory controller driving the command and address pins
`timescale 1ns/10ps
`default_nettype none
module dmr_ctrl_model (
  // Reference clock that times pin changes
  input  wire logic       i_ref_clk,
  // Command pins toward the device
  output logic            o_ck,
  output logic            o_cke_n,
  output logic            o_cs_n,
  output logic            o_ras_n,
  output logic            o_cas_n,
  output logic            o_we_n,
  output logic [7:0]      o_adr
);
  // Command clock runs free, 80 ns, phase unrelated to the reference
  initial
  begin
    o_ck = 1'b0;
    #7;
    forever #40 o_ck = ~o_ck;
  end

  // Pins start deselected with the clock enabled
  initial
  begin
    o_cke_n = 1'b0;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_adr = 8'h5a;
  end

  // One beat: change after the command clock falls, hold past its rise
  task automatic beat(input logic cke_n, input logic [3:0] cmd,
                      input logic [7:0] adr);
  begin
    @(negedge o_ck);
    @(negedge i_ref_clk);
    o_cke_n = cke_n;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd;
    o_adr = adr;
    @(posedge o_ck);
  end
  endtask

  // Two-beat configuration write, then idle beats with a toggled bus
  // Idle beats give the register-set delay; no reads are ever issued
  task automatic write_word(input logic [2:0] bank,
                            input logic [12:0] op, input int gap);
  begin
    beat(1'b0, 4'h0, {bank, op[12:8]});
    beat(1'b0, 4'hf, {op[6], op[5], op[1], op[2],
                      op[3], op[0], op[7], op[4]});
    repeat (gap) beat(1'b0, 4'hf, ~o_adr);
  end
  endtask
endmodule // dmr_ctrl_model
`default_nettype wire

// ---- dmr_mode_regs_tb_top.sv ----
// Self-checking testbench of the configuration word block
`timescale 1ns/10ps
`default_nettype none
module dmr_mode_regs_tb_top;
  import dmr_pkg::*;
  // Expected state after one word change
  typedef struct packed {
    logic [12:0] base;
    logic [12:0] ext;
    logic [12:0] ext2;
    logic        lp;
  } dmr_note_type;

  localparam logic [1:0] TERM_DEFAULT_TB = TERM_CA_ONLY; // Power-up code

  logic         i_ref_clk, i_rst;    // Clock and reset
  logic         ck, cke_n, cs_n, ras_n, cas_n, we_n;
  logic [7:0]   adr;                 // Address pins
  logic [12:0]  o_base_mode_word, o_extended_config_word;
  logic [12:0]  o_second_extended_word;
  logic [2:0]   o_write_recovery, o_preamble_len;
  logic [1:0]   o_vendor_info;
  logic         o_test_mode, o_dll_reset, o_auto_calibration;
  logic         o_data_term_en, o_ca_term_en, o_term_half;
  logic         o_low_power_termination, o_dll_enable;
  logic         o_bus_inversion_rd, o_bus_inversion_wr;
  logic         o_bus_inversion_mode, o_self_refresh;
  dmr_note_type notes[$];            // Pending expectations
  dmr_note_type n;                   // Note under comparison
  logic [38:0]  last_words, last_pushed;
  logic [12:0]  exp_base, exp_ext, exp_ext2, op;
  logic         exp_lp, init_on;
  int           failures, num_checks, cycles, seed;

  // Reference clock, 10 ns
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  dmr_ctrl_model model_u (.i_ref_clk(i_ref_clk), .o_ck(ck),
    .o_cke_n(cke_n), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_adr(adr));

  dmr_mode_regs #(.INIT_CYCLES_P(50), .DLL_CYCLES_P(8)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ck(ck), .i_cke_n(cke_n),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_adr(adr), .o_base_mode_word(o_base_mode_word),
    .o_extended_config_word(o_extended_config_word),
    .o_second_extended_word(o_second_extended_word),
    .o_write_recovery(o_write_recovery), .o_test_mode(o_test_mode),
    .o_dll_reset(o_dll_reset), .o_auto_calibration(o_auto_calibration),
    .o_data_term_en(o_data_term_en), .o_ca_term_en(o_ca_term_en),
    .o_term_half(o_term_half),
    .o_low_power_termination(o_low_power_termination),
    .o_preamble_len(o_preamble_len), .o_dll_enable(o_dll_enable),
    .o_bus_inversion_rd(o_bus_inversion_rd),
    .o_bus_inversion_wr(o_bus_inversion_wr),
    .o_bus_inversion_mode(o_bus_inversion_mode),
    .o_vendor_info(o_vendor_info), .o_self_refresh(o_self_refresh));

  // Print counts and verdict, then stop
  task automatic end_of_test;
  begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  // One compare, four-state exact
  task automatic chk(input logic [12:0] got, input logic [12:0] exp,
                     input string what);
  begin
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  // Record a note only when a stored word is to change
  task automatic push_note;
  begin
    if ({exp_base, exp_ext, exp_ext2} != last_pushed)
      notes.push_back('{exp_base, exp_ext, exp_ext2, exp_lp});
    last_pushed = {exp_base, exp_ext, exp_ext2};
  end
  endtask

  // Configuration write with its expectation noted first
  task automatic wr(input logic [2:0] bank, input logic [12:0] v,
                    input int gap);
  begin
    case (bank)
      BANK_BASE: exp_base = v;
      BANK_EXT:  exp_ext = init_on ?
                   {v[12:4], TERM_DEFAULT_TB, v[1:0]} : v;
      BANK_EXT2: exp_ext2 = v;
      BANK_EXT3: exp_lp = init_on ? 1'b0 : v[EXT3_LPT_BIT];
      default:   ;                               // Reserved codes
    endcase
    push_note();
    if (bank == BANK_BASE && v[BASE_DLL_RST_BIT])
    begin
      exp_base[BASE_DLL_RST_BIT] = 1'b0;
      push_note();
    end
    model_u.write_word(bank, v, gap);
  end
  endtask

  // Watcher: each word change consumes the oldest note
  always @(negedge i_ref_clk)
  begin
    if (!i_rst && {o_base_mode_word, o_extended_config_word,
                   o_second_extended_word} !== last_words)
    begin
      if (notes.size() == 0)
        chk(13'h1, 13'h0, "unexpected change");
      else
      begin
        n = notes.pop_front();
        chk(o_base_mode_word, n.base, "base");
        chk(o_extended_config_word, n.ext, "ext");
        chk(o_second_extended_word, n.ext2, "ext2");
        chk(13'(o_write_recovery), 13'(n.base[2:0]), "wr");
        chk(13'(o_test_mode), 13'(n.base[7]), "test");
        chk(13'(o_dll_reset), 13'(n.base[8]), "dr");
        chk(13'(o_auto_calibration), 13'(n.ext[1:0] == IMP_AUTO),
            "cal");
        chk(13'(o_ca_term_en), 13'(n.ext[3:2] != TERM_ALL_OFF),
            "ca");
        chk(13'(o_data_term_en), 13'(n.ext[3]), "dq");
        chk(13'(o_term_half), 13'(n.ext[3:2] == TERM_HALF),
            "half");
        chk(13'(o_low_power_termination), 13'(n.lp & n.ext[3]),
            "lp");
        chk(13'(o_preamble_len), 13'(n.ext[6:4]), "pre");
        chk(13'(o_dll_enable), 13'(!n.ext[7]), "dll");
        chk(13'({o_bus_inversion_mode, o_bus_inversion_wr,
                 o_bus_inversion_rd}), 13'(n.ext[10:8]),
            "inv");
        chk(13'(o_vendor_info), 13'(n.ext[12:11]), "vid");
      end
    end
    last_words = {o_base_mode_word, o_extended_config_word,
                  o_second_extended_word};
  end

  // Hang guard on reference cycles
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    {failures, num_checks, cycles} = '0;
    seed = 83;
    {exp_base, exp_ext, exp_ext2, exp_lp} = {BASE_RESET, EXT_RESET,
                                             EXT2_RESET, 1'b0};
    last_pushed = {BASE_RESET, EXT_RESET, EXT2_RESET};
    init_on = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    // Power-up window: forced termination and low-power bit
    wr(BANK_EXT3, 13'h0020, 0);
    wr(BANK_EXT, 13'h0770, 1);
    repeat (30) @(negedge i_ref_clk);
    init_on = 1'b0;
    wr(BANK_EXT3, 13'h0020, 1);
    // Every termination code, random other fields, loop enabled
    for (int t = 0; t < 4; t++)
    begin
      op = 13'($random(seed));
      wr(BANK_EXT, {op[12:8], 1'b0, op[6:4], 2'(t), op[1:0]},
         1);
    end
    // Base words: recovery count fixed, loop reset self-clears
    op = 13'($random(seed));
    wr(BANK_BASE, {op[12:9], 1'b0, op[7:3], 3'h5}, 1);
    wr(BANK_BASE, {op[12:9], 1'b1, ~op[7], op[6:3], 3'h6}, 1);
    wr(BANK_EXT2, 13'($random(seed)), 1);
    // Reserved bank code and a non-write command change nothing
    wr(3'h5, 13'h1fff, 1);
    model_u.beat(1'b0, 4'h3, 8'h1f);
    model_u.beat(1'b0, 4'hf, 8'h00);
    // Back to back writes to two words
    wr(BANK_EXT2, 13'($random(seed)), 0);
    wr(BANK_BASE, 13'h0a5a, 1);
    // Loop off, then self refresh round trip turns it on again
    wr(BANK_EXT, 13'h0084, 1);
    model_u.beat(1'b1, 4'h1, 8'h33);
    model_u.beat(1'b1, 4'hf, 8'hcc);
    repeat (6) @(negedge i_ref_clk);
    chk(13'(o_self_refresh), 13'h1, "sr in");
    exp_ext[EXT_DLL_OFF_BIT] = 1'b0;
    push_note();
    model_u.beat(1'b0, 4'hf, 8'h33);
    model_u.beat(1'b0, 4'hf, 8'hcc);
    repeat (6) @(negedge i_ref_clk);
    chk(13'(o_self_refresh), 13'h0, "sr out");
    repeat (40) @(negedge i_ref_clk);
    chk(13'(notes.size()), 13'h0, "notes left");
    end_of_test();
  end
endmodule // dmr_mode_regs_tb_top
`default_nettype wire
